// ### serial_port_pkg.sv
// Constants, types and frame encodings for the asynchronous serial port
// Summary of operation
// R1: Separate 16-deep FIFOs, or single holding byte
// R2: Start, 5-9 data, optional parity, 1-2 stops
// R3: Even, odd, space, mark or no parity
// R4: Transmit holding is write-only, sixteen may queue
// R5: After reset holding empty flag reads one
// R6: Transmit data least significant bit first
// R7: Idle transmit line rests high
// R8: Each bit lasts sixteen baud ticks
// R9: Software picks mark for address, space data
// R10: Data ready sets on store, clears when drained
// R11: Unused upper received bits read zero
// R12: Nine-bit mode flags high ninth bit address
// R13: Receiver syncs on start falling edge, 16x
// R14: Detect framing, parity, overrun and break errors
// R15: Two modem outputs, four inputs, ring trailing edge
// R16: Modem change interrupt clears on status read
// R17: Holding-empty and complete interrupts, cleared by write
// R18: Receive ready at trigger level or one byte
// R19: Time-out after four idle character times
// R20: Ready and time-out share one enable
// R21: Line status interrupt follows errored head byte
// R22: Error summary while errored byte stored
// R23: Sixteen-bit down-counter reloads after one, pulses
// R24: Divisor resets to two, write restarts count
// R25: Overrun discards new character, keeps stored
// R26: Loop mode wires output back, line idles high
package serial_port_pkg;
  localparam int unsigned DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam logic [15:0] DIV_RESET = 16'h0002;
  localparam logic [15:0] DIV_LAST = 16'h0001;
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] TICKS_MID = 4'h7;
  localparam logic [5:0] TOUT_CHARS = 6'h04;
  localparam int unsigned LS_DR = 0;
  localparam int unsigned LS_OE = 1;
  localparam int unsigned LS_PE = 2;
  localparam int unsigned LS_FE = 3;
  localparam int unsigned LS_BI = 4;
  localparam int unsigned LS_TX_HOLD_EMPTY = 5;
  localparam int unsigned LS_TEMT = 6;
  localparam int unsigned LS_ERR = 7;
  typedef enum logic [2:0] {
    PAR_NONE = 3'b000, PAR_ODD = 3'b001, PAR_EVEN = 3'b011,
    PAR_MARK = 3'b101, PAR_SPACE = 3'b111
  } parity_e;
  // Line format from software
  typedef struct packed {
    logic [3:0] data_bits;  // 5 to 9
    parity_e parity;
    logic two_stop;
    logic send_break;
  } line_cfg_s;
  // Received entry: data plus per-byte errors
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } rx_entry_s;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000, SER_START = 3'b001, SER_DATA = 3'b010,
    SER_PAR = 3'b011, SER_STOP = 3'b100
  } ser_e;
endpackage

// ### async_serial_port_fifo.sv
// Serial port top with baud divider, transmitter, receiver and modem logic
`timescale 1ns/100ps
`default_nettype none

// Small valid/ready FIFO
module sp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH)) || flush;
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && (cnt_q != (AW+1)'(DEPTH)) && !flush;
  assign pop = out_valid && out_ready && !flush;
  assign out_data = mem[rd_q];
  assign count = cnt_q;
  // Pointers and count; flush empties at once
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + AW'(1);
      if (pop)
        rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage written without reset
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end
endmodule

module async_serial_port_fifo
  import serial_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_reset,  // Synchronous reset; modem deltas and input synchronisers keep their values
  input wire serial_port_pkg::line_cfg_s line_cfg,
  input wire logic fifo_enable,
  input wire logic [4:0] rx_trigger,
  input wire logic loop_mode,
  input wire logic [15:0] divisor,
  input wire logic divisor_write,
  input wire logic tx_hold_reg_write,
  input wire logic [7:0] tx_hold_reg_data,
  output logic tx_hold_reg_ready,
  input wire logic rx_buffer_reg_read,
  output logic [7:0] rx_buffer_reg,
  output logic rx_ninth_bit,
  input wire logic line_status_read,
  output logic [7:0] line_status_reg,
  input wire logic modem_status_read,
  output logic [7:0] modem_status_reg,
  input wire logic [1:0] modem_out,  // Request-to-send, terminal-ready
  input wire logic [3:0] modem_in_pins,  // Clear, set-ready, ring, carrier
  output logic [1:0] modem_out_pins,
  input wire logic ien_rx,
  input wire logic ien_tx_empty,
  input wire logic ien_tx_done,
  input wire logic ien_line,
  input wire logic ien_modem,
  output logic irq_rx_ready,
  output logic irq_rx_timeout,
  output logic irq_tx_empty,
  output logic irq_tx_done,
  output logic irq_line,
  output logic irq_modem,
  input wire logic rx_pin,
  output logic tx_pin
);
  import serial_port_pkg::*;

  // ************************************************************
  // Baud divider
  // ************************************************************
  logic [15:0] baud_divider_q;
  logic [15:0] div_latch_q;
  logic tick;
  assign tick = (baud_divider_q == DIV_LAST);
  // Count down; reload after 0001 and pulse once
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_latch_q <= DIV_RESET;  // R24
      baud_divider_q <= DIV_RESET;
    end
    else if (soft_reset)
    begin
      div_latch_q <= DIV_RESET;
      baud_divider_q <= DIV_RESET;
    end
    else if (divisor_write)
    begin
      div_latch_q <= divisor;  // R24
      baud_divider_q <= divisor;
    end
    else if (tick)
      baud_divider_q <= div_latch_q;  // R23
    else
      baud_divider_q <= baud_divider_q - 16'h0001;  // R23
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  // Two stages before any logic looks at pins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
    end
    else
    begin
      sync1_q <= {rx_pin, modem_in_pins};
      sync2_q <= sync1_q;
    end
  end

  // ************************************************************
  // Transmit path
  // ************************************************************
  logic tx_flush;
  logic txf_valid;
  logic txf_pop;
  logic [8:0] txf_data;
  logic [4:0] txf_count;
  logic [4:0] tx_cap;
  logic tx_in_ready;
  assign tx_flush = soft_reset;
  assign tx_cap = fifo_enable ? 5'(DEPTH) : 5'h01;  // R1
  assign tx_hold_reg_ready = tx_in_ready && (txf_count < tx_cap);  // R4
  sp_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(PTR_W)) u_txf (
    .sys_clk(sys_clk), .rst_n(rst_n), .flush(tx_flush),
    .in_valid(tx_hold_reg_write && tx_hold_reg_ready), .in_ready(tx_in_ready),
    .in_data({1'b0, tx_hold_reg_data}), .out_valid(txf_valid),
    .out_ready(txf_pop), .out_data(txf_data), .count(txf_count)
  );
  ser_e tx_st_q;
  logic [3:0] tx_tick_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  logic tx_par_q;
  logic tx_line_q;
  logic tx_stop2_q;
  logic tx_done_q;
  logic bit_end;
  assign bit_end = tick && (tx_tick_q == TICKS_LAST);  // R8
  assign txf_pop = (tx_st_q == SER_IDLE) && txf_valid && tick;
  // Frame sequencer: start, data LSB first, parity, stops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_q <= SER_IDLE;
      tx_tick_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      tx_par_q <= 1'b0;
      tx_line_q <= 1'b1;
      tx_stop2_q <= 1'b0;
      tx_done_q <= 1'b0;
    end
    else if (soft_reset)
    begin
      tx_st_q <= SER_IDLE;
      tx_line_q <= 1'b1;
      tx_done_q <= 1'b0;
    end
    else
    begin
      if (tx_hold_reg_write)
        tx_done_q <= 1'b0;  // R17
      if (tick)
        tx_tick_q <= tx_tick_q + 4'h1;
      unique case (tx_st_q)
        SER_IDLE:
        begin
          tx_line_q <= 1'b1;  // R7
          tx_tick_q <= '0;
          if (txf_pop)
          begin
            tx_sh_q <= txf_data;
            tx_par_q <= ^txf_data[7:0];
            tx_line_q <= 1'b0;  // R2
            tx_st_q <= SER_START;
          end
        end
        SER_START:
          if (bit_end)
          begin
            tx_line_q <= tx_sh_q[0];  // R6
            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            tx_bit_q <= 4'h1;
            tx_st_q <= SER_DATA;
          end
        SER_DATA:
          if (bit_end)
          begin
            if (tx_bit_q < line_cfg.data_bits)
            begin
              tx_line_q <= tx_sh_q[0];  // R6
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
            end
            else if (line_cfg.parity != PAR_NONE)
            begin
              unique case (line_cfg.parity)  // R3
                PAR_EVEN: tx_line_q <= tx_par_q;
                PAR_ODD: tx_line_q <= ~tx_par_q;
                PAR_MARK: tx_line_q <= 1'b1;  // R9
                PAR_SPACE: tx_line_q <= 1'b0;
                default: tx_line_q <= 1'b1;
              endcase
              tx_st_q <= SER_PAR;
            end
            else
            begin
              tx_line_q <= 1'b1;
              tx_stop2_q <= line_cfg.two_stop;
              tx_st_q <= SER_STOP;
            end
          end
        SER_PAR:
          if (bit_end)
          begin
            tx_line_q <= 1'b1;
            tx_stop2_q <= line_cfg.two_stop;
            tx_st_q <= SER_STOP;
          end
        SER_STOP:
          if (bit_end)
          begin
            if (tx_stop2_q)
              tx_stop2_q <= 1'b0;  // R2
            else
            begin
              tx_st_q <= SER_IDLE;
              tx_done_q <= 1'b1;  // R17
            end
          end
        default: tx_st_q <= SER_IDLE;
      endcase
    end
  end
  logic tx_serial;
  assign tx_serial = tx_line_q && !line_cfg.send_break;
  // Output register; loop mode parks the line high
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_pin <= 1'b1;
      modem_out_pins <= 2'h0;
    end
    else
    begin
      tx_pin <= loop_mode ? 1'b1 : tx_serial;  // R26
      modem_out_pins <= loop_mode ? 2'h0 : modem_out;
    end
  end

  // ************************************************************
  // Receive path
  // ************************************************************
  logic rx_line;
  logic [3:0] mdm_in;
  assign rx_line = loop_mode ? tx_serial : sync2_q[4];  // R26
  assign mdm_in = loop_mode ? {modem_out[0], 1'b0, modem_out} : sync2_q[3:0];
  ser_e rx_st_q;
  logic [3:0] rx_tick_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic rx_allzero_q;
  logic rx_push;
  rx_entry_s rx_new;
  logic rxf_in_ready;
  logic rxf_valid;
  logic [4:0] rxf_count;
  rx_entry_s rxf_head;
  logic overrun_q;
  logic ninth_hi;
  logic par_bad;
  assign ninth_hi = (line_cfg.data_bits == 4'h9) && rx_sh_q[8];
  // Receive state: sample mid-bit after start edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_q <= SER_IDLE;
      rx_tick_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_allzero_q <= 1'b1;
      rx_push <= 1'b0;
      rx_new <= '0;
    end
    else if (soft_reset)
    begin
      rx_st_q <= SER_IDLE;
      rx_push <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      if (tick)
      begin
        rx_tick_q <= rx_tick_q + 4'h1;
        unique case (rx_st_q)
          SER_IDLE:
            if (!rx_line)
            begin
              rx_st_q <= SER_START;  // R13
              rx_tick_q <= '0;
            end
          SER_START:
            if (rx_tick_q == TICKS_MID)
            begin
              rx_tick_q <= '0;
              rx_bit_q <= '0;
              rx_sh_q <= '0;
              rx_allzero_q <= 1'b1;
              rx_st_q <= rx_line ? SER_IDLE : SER_DATA;
            end
          SER_DATA:
            if (rx_tick_q == TICKS_LAST)
            begin
              rx_sh_q <= {1'b0, rx_sh_q[8:1]} | (9'(rx_line) << (line_cfg.data_bits - 4'h1));
              rx_allzero_q <= rx_allzero_q && !rx_line;
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q + 4'h1 == line_cfg.data_bits)
                rx_st_q <= (line_cfg.parity != PAR_NONE) ? SER_PAR : SER_STOP;
            end
          SER_PAR:
            if (rx_tick_q == TICKS_LAST)
            begin
              rx_new.par <= par_bad;  // R14
              rx_allzero_q <= rx_allzero_q && !rx_line;
              rx_st_q <= SER_STOP;
            end
          SER_STOP:
            if (rx_tick_q == TICKS_LAST)
            begin
              rx_new.data <= rx_sh_q[7:0];  // R11
              rx_new.frm <= !rx_line;  // R14
              rx_new.brk <= rx_allzero_q && !rx_line;  // R14
              if (line_cfg.parity == PAR_NONE)
                rx_new.par <= ninth_hi;  // R12
              rx_push <= 1'b1;
              rx_st_q <= SER_IDLE;
            end
          default: rx_st_q <= SER_IDLE;
        endcase
      end
    end
  end
  // Parity check; ninth bit high counts as address
  always_comb
  begin
    unique case (line_cfg.parity)  // R3
      PAR_EVEN: par_bad = rx_line != ^rx_sh_q;
      PAR_ODD: par_bad = rx_line == ^rx_sh_q;
      PAR_MARK: par_bad = !rx_line;
      PAR_SPACE: par_bad = rx_line;
      default: par_bad = 1'b0;
    endcase
    if (ninth_hi)
      par_bad = 1'b1;  // R12
  end
  logic [4:0] rx_cap;
  logic rx_room;
  logic rx_pop;
  assign rx_cap = fifo_enable ? 5'(DEPTH) : 5'h01;  // R1
  assign rx_room = rxf_in_ready && (rxf_count < rx_cap);
  assign rx_pop = rx_buffer_reg_read && rxf_valid;
  sp_fifo #(.WIDTH(11), .DEPTH(DEPTH), .AW(PTR_W)) u_rxf (
    .sys_clk(sys_clk), .rst_n(rst_n), .flush(soft_reset),
    .in_valid(rx_push && rx_room), .in_ready(rxf_in_ready),  // R25
    .in_data(rx_new), .out_valid(rxf_valid), .out_ready(rx_pop),
    .out_data(rxf_head), .count(rxf_count)
  );
  // Data outputs registered from the head entry
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_buffer_reg <= '0;
      rx_ninth_bit <= 1'b0;
    end
    else
    begin
      rx_buffer_reg <= rxf_valid ? rxf_head.data : 8'h00;
      rx_ninth_bit <= rxf_valid && rxf_head.par && (line_cfg.data_bits == 4'h9);
    end
  end
  // Count errored entries held in the receive FIFO
  logic [4:0] err_cnt_q;
  logic new_err;
  logic head_err;
  assign new_err = rx_push && rx_room && (rx_new.par || rx_new.frm || rx_new.brk);
  assign head_err = rxf_valid && (rxf_head.par || rxf_head.frm || rxf_head.brk);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      err_cnt_q <= '0;
    else if (soft_reset)
      err_cnt_q <= '0;
    else
      err_cnt_q <= err_cnt_q + 5'(new_err) - 5'(rx_pop && head_err);  // R22
  end
  // Overrun and line-status interrupt latch; a new event beats the read clear
  logic line_irq_q;
  logic head_seen_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_q <= 1'b0;
      line_irq_q <= 1'b0;
      head_seen_q <= 1'b0;
    end
    else if (soft_reset)
    begin
      overrun_q <= 1'b0;
      line_irq_q <= 1'b0;
      head_seen_q <= 1'b0;
    end
    else
    begin
      head_seen_q <= head_err && !rx_pop;
      if (rx_push && !rx_room)
        overrun_q <= 1'b1;  // R25
      else if (line_status_read)
        overrun_q <= 1'b0;
      if ((rx_push && !rx_room) || (head_err && !head_seen_q))
        line_irq_q <= 1'b1;  // R21
      else if (line_status_read || !head_err && !overrun_q)
        line_irq_q <= 1'b0;  // R21
    end
  end
  // Time-out: four idle character times of 16 ticks per bit
  logic [9:0] tout_q;
  logic [9:0] char_ticks;
  logic tout_flag_q;
  assign char_ticks = 10'({line_cfg.data_bits + 4'h3, 4'h0});
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tout_q <= '0;
      tout_flag_q <= 1'b0;
    end
    else if (soft_reset || !rxf_valid)
    begin
      tout_q <= '0;
      tout_flag_q <= 1'b0;  // R19
    end
    else if (rx_pop || rx_push)
      tout_q <= '0;
    else if (tick && tout_q != 10'h3ff)
    begin
      tout_q <= tout_q + 10'h001;
      if (12'(tout_q) + 12'h001 >= 12'(char_ticks) * 12'(TOUT_CHARS))
        tout_flag_q <= tout_flag_q || (rxf_count < rx_trigger);  // R19
    end
  end

  // ************************************************************
  // Modem status
  // ************************************************************
  logic [3:0] mdm_prev_q;
  logic [3:0] delta_q;
  logic [3:0] delta_set;
  assign delta_set = {mdm_in[3] ^ mdm_prev_q[3], mdm_prev_q[2] && !mdm_in[2],
                      mdm_in[1:0] ^ mdm_prev_q[1:0]};  // R15
  // Deltas stick until read; a fresh change beats the clear
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdm_prev_q <= '1;  // Same as the synchroniser reset, so no false edge
      delta_q <= '0;
    end
    else
    begin
      mdm_prev_q <= mdm_in;
      delta_q <= delta_set | (modem_status_read ? 4'h0 : delta_q);  // R16
    end
  end
  assign modem_status_reg = {mdm_in, delta_q};

  // ************************************************************
  // Status and interrupt outputs
  // ************************************************************
  assign line_status_reg = {err_cnt_q != 5'h00, !txf_valid && tx_st_q == SER_IDLE,
                            !txf_valid, rxf_valid && rxf_head.brk,
                            rxf_valid && rxf_head.frm, rxf_valid && rxf_head.par,
                            overrun_q, rxf_valid};  // R5 R10 R14 R22
  assign irq_tx_empty = ien_tx_empty && !txf_valid;  // R17 R5
  assign irq_tx_done = ien_tx_done && tx_done_q && !txf_valid;  // R17
  assign irq_rx_ready = ien_rx && (fifo_enable ? rxf_count >= rx_trigger : rxf_valid);  // R18 R20
  assign irq_rx_timeout = ien_rx && tout_flag_q;  // R20
  assign irq_line = ien_line && line_irq_q;  // R21
  assign irq_modem = ien_modem && (delta_q != 4'h0);  // R16

  // ************************************************************
  // Checks
  // ************************************************************
  a_idle_high: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R7
    (tx_st_q == SER_IDLE && !line_cfg.send_break && !loop_mode) |=> tx_pin)
    else $error("tx line not idle high");
  a_div_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R23
    (tick && !divisor_write && !soft_reset) |=> baud_divider_q == div_latch_q)
    else $error("divider did not reload");
  a_ready_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R10
    line_status_reg[LS_DR] == (rxf_count != 5'h00))
    else $error("ready flag wrong");
  a_overrun_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R25
    (rx_push && !rx_room && !rx_pop && !soft_reset) |=> $stable(rxf_count))
    else $error("overrun changed fifo");
  // A frame ending in the write cycle sets done again; the set wins
  a_tx_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R17
    (tx_hold_reg_write && !soft_reset && !(tx_st_q == SER_STOP && bit_end))
    |=> !tx_done_q)
    else $error("done not cleared");
  a_modem_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R16
    (modem_status_read && delta_set == 4'h0) |=> delta_q == 4'h0)
    else $error("modem delta not cleared");
  a_err_summary: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R22
    head_err |-> line_status_reg[LS_ERR])
    else $error("error summary low");
  a_fifo_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)  // R1
    !fifo_enable |-> rxf_count <= 5'h01)
    else $error("holding byte exceeded");
endmodule

`default_nettype wire

// ### serial_remote.sv
// Remote serial device model: sends frames and decodes 8-bit frames
`timescale 1ns/100ps
`default_nettype none
module serial_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got_q[$];  // Bytes decoded from the device
  logic [7:0] sh;  // Receive shifter
  initial line_out = 1'b1;  // Line rests at mark
  // Frame: start, data low bit first, optional parity, stop
  task automatic send(input logic [7:0] d, input int nb, input int par, input logic stop);
    int n;
    n = nb + 2 + int'(par >= 0);
    for (int i = 0; i < n; i++)
    begin
      line_out <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == n-1) ? stop : par[0];
      repeat (BIT_CLKS) @(posedge sys_clk);
    end
    line_out <= 1'b1;
  endtask
  // Sample mid-bit from the falling start edge; a wrong bit length drifts off centre
  initial forever
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CLKS) @(posedge sys_clk);
      if (i < 8)
        sh[i] = line_in;
    end
    got_q.push_back(sh);
  end
endmodule
`default_nettype wire

// ### async_serial_port_fifo_test.sv
// Self-checking bench for the serial port
`timescale 1ns/100ps
`default_nettype none
module async_serial_port_fifo_test;
  import serial_port_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, fifo_enable = 1'b1, loop_mode = 1'b0;
  logic divisor_write = 1'b0, tx_hold_reg_write = 1'b0, rx_buffer_reg_read = 1'b0;
  logic line_status_read = 1'b0, modem_status_read = 1'b0, ien_rx = 1'b1, ien_tx_empty = 1'b1;
  logic ien_tx_done = 1'b1, ien_line = 1'b1, ien_modem = 1'b1;
  line_cfg_s line_cfg = '{4'h8, PAR_NONE, 1'b0, 1'b0};
  logic [4:0] rx_trigger = 5'h01;
  logic [15:0] divisor = 16'h0002;  // Reset divisor: 32 clocks a bit
  logic [7:0] tx_hold_reg_data = 8'h00;
  logic [1:0] modem_out = 2'h1;
  logic [3:0] modem_in_pins = 4'hb;  // Ring input starts low
  logic tx_hold_reg_ready, rx_ninth_bit, tx_pin, rx_pin, irq_rx_ready, irq_rx_timeout;
  logic irq_tx_empty, irq_tx_done, irq_line, irq_modem, tx_ok;
  logic [7:0] rx_buffer_reg, line_status_reg, modem_status_reg, d;
  logic [7:0] exp_q[$];
  logic [1:0] modem_out_pins;
  int fail_count = 0, samples_checked = 0, cycles = 0, nb;
  async_serial_port_fifo u_dut (.*);
  serial_remote #(.BIT_CLKS(32)) u_remote (.sys_clk(sys_clk), .line_in(tx_pin), .line_out(rx_pin));
  always #50 sys_clk = ~sys_clk;
  // Hang guard, far above the expected run length
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  // Received data keeps only the programmed number of bits
  function automatic logic [7:0] exp_data(input logic [7:0] v, input int n);
    return v & 8'((9'h1 << n) - 9'h1);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs set by this bench change one nanosecond after the edge; the remote drives its line on the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic push(input logic [7:0] v);
    while (tx_hold_reg_ready !== 1'b1)
      tick(1);
    tx_hold_reg_data = v;
    tx_hold_reg_write = 1'b1;
    tick(1);
    tx_hold_reg_write = 1'b0;
    tick(1);
  endtask
  task automatic wait_ready();
    while (line_status_reg[0] !== 1'b1)
      tick(1);
    tick(2);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'he1d31001));
    tick(8);
    rst_n = 1'b1;
    tick(2);
    check("holding empty", {7'h0, line_status_reg[5]}, 8'h01);
    check("idle line", {7'h0, tx_pin}, 8'h01);
    check("empty irq", {7'h0, irq_tx_empty}, 8'h01);
    check("modem out", {6'h0, modem_out_pins}, {6'h0, modem_out});
    // Back-to-back writes, decoded by the remote
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      exp_q.push_back(d);
      push(d);
    end
    while (u_remote.got_q.size() < 4)
      tick(1);
    foreach (exp_q[i]) check("tx byte", u_remote.got_q[i], exp_q[i]);
    tick(40);
    check("done irq", {7'h0, irq_tx_done}, 8'h01);
    check("tx empty", {7'h0, line_status_reg[6]}, 8'h01);
    // Receive: plain, short, bad parity, bad stop
    for (int c = 0; c < 4; c++)
    begin
      d = 8'($urandom);
      nb = (c == 1) ? 5 : 8;
      line_cfg.data_bits = 4'(nb);
      line_cfg.parity = (c == 2) ? PAR_EVEN : PAR_NONE;
      u_remote.send(d, nb, (c == 2) ? int'(~^d) : -1, c != 3);
      wait_ready();
      check("rx data", rx_buffer_reg, exp_data(d, nb));
      check("parity err", {7'h0, line_status_reg[2]}, {7'h0, c == 2});
      check("framing err", {7'h0, line_status_reg[3]}, {7'h0, c == 3});
      check("line irq", {7'h0, irq_line}, {7'h0, c >= 2});
      check("error summary", {7'h0, line_status_reg[7]}, {7'h0, c >= 2});
      check("ready irq", {7'h0, irq_rx_ready}, 8'h01);
      line_status_read = 1'b1;
      rx_buffer_reg_read = 1'b1;
      tick(1);
      line_status_read = 1'b0;
      rx_buffer_reg_read = 1'b0;
      tick(2);
      check("ready clear", {7'h0, line_status_reg[0]}, 8'h00);
      check("line irq clear", {7'h0, irq_line}, 8'h00);
    end
    // Break frame sits in the single holding byte, the next frame overruns
    fifo_enable = 1'b0;
    u_remote.send(8'h00, 8, -1, 1'b0);
    tick(40);
    u_remote.send(8'h3c, 8, -1, 1'b1);
    tick(4);
    check("break", {7'h0, line_status_reg[4]}, 8'h01);
    check("overrun", {7'h0, line_status_reg[1]}, 8'h01);
    check("kept byte", rx_buffer_reg, 8'h00);
    line_status_read = 1'b1;
    rx_buffer_reg_read = 1'b1;
    tick(1);
    line_status_read = 1'b0;
    rx_buffer_reg_read = 1'b0;
    fifo_enable = 1'b1;
    // Clear deltas left from reset; then ring rise ignored, ring fall flagged
    modem_status_read = 1'b1;
    tick(1);
    modem_status_read = 1'b0;
    modem_in_pins = 4'hf;
    tick(5);
    check("ring rise", {7'h0, modem_status_reg[2]}, 8'h00);
    modem_in_pins = 4'ha;
    tick(5);
    check("modem deltas", modem_status_reg, 8'ha5);
    check("modem irq", {7'h0, irq_modem}, 8'h01);
    modem_status_read = 1'b1;
    tick(1);
    modem_status_read = 1'b0;
    tick(1);
    check("modem irq clear", {7'h0, irq_modem}, 8'h00);
    // Loop mode: byte comes back inside, outer line held high
    loop_mode = 1'b1;
    rx_trigger = 5'h02;
    line_cfg.data_bits = 4'h8;
    d = 8'($urandom);
    push(d);
    tx_ok = 1'b1;
    repeat (500)
    begin
      tick(1);
      if (tx_pin !== 1'b1)
        tx_ok = 1'b0;
    end
    check("loop line high", {7'h0, tx_ok}, 8'h01);
    check("loop data", rx_buffer_reg, d);
    // One byte below the trigger level, left alone past four character times
    tick(1600);
    check("timeout irq", {7'h0, irq_rx_timeout}, 8'h01);
    check("below trigger", {7'h0, irq_rx_ready}, 8'h00);
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(2);
    check("sync reset empty", {7'h0, line_status_reg[5]}, 8'h01);
    check("flush ready", {7'h0, line_status_reg[0]}, 8'h00);
    check("timeout clear", {7'h0, irq_rx_timeout}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
